// >>> sxsalu_exec.sv
`include "sxsalu_params.svh"

module sxsalu_exec (
  input sxsalu_pkg::sxsalu_op_type op_i,
  input logic dest_i,
  input logic [7:0] acc_i,
  input logic [7:0] literal_i,
  input logic [7:0] file_i,
  output logic [7:0] result_o,
  output sxsalu_pkg::sxsalu_flags_type flags_o,
  output sxsalu_pkg::sxsalu_flags_type flag_wr_o,
  output logic acc_wr_o,
  output logic file_wr_o
);
  import sxsalu_pkg::*;

  logic [7:0] minuend; // Literal or file operand of a subtract
  logic [8:0] diff; // Full difference with borrow out
  logic [4:0] ndiff; // Low nibble difference with borrow out

  // Subtract datapath shared by both subtract forms
  always_comb begin
    minuend = (op_i == SXSALU_OP_LIT_MINUS_ACC) ? literal_i : file_i;
    diff = {1'b0, minuend} - {1'b0, acc_i};
    ndiff = {1'b0, minuend[3:0]} - {1'b0, acc_i[3:0]};
  end

  // Operation select, flag update and destination
  always_comb begin
    result_o = 8'h00;
    flag_wr_o = '0;
    acc_wr_o = 1'b0;
    file_wr_o = 1'b0;
    case (op_i)
      SXSALU_OP_LIT_MINUS_ACC: begin
        result_o = diff[7:0];
        acc_wr_o = 1'b1;
        flag_wr_o = 3'h7;
      end
      SXSALU_OP_FILE_MINUS_ACC: begin
        result_o = diff[7:0];
        flag_wr_o = 3'h7;
        acc_wr_o = ~dest_i;
        file_wr_o = dest_i;
      end
      SXSALU_OP_ACC_XOR_FILE: begin
        result_o = acc_i ^ file_i;
        flag_wr_o.zero = 1'b1;
        acc_wr_o = ~dest_i;
        file_wr_o = dest_i;
      end
      SXSALU_OP_NIBBLE_EXCHANGE: begin
        result_o = {file_i[3:0], file_i[7:4]};
        acc_wr_o = ~dest_i;
        file_wr_o = dest_i;
      end
      SXSALU_OP_ACC_XOR_LITERAL: begin
        result_o = acc_i ^ literal_i;
        acc_wr_o = 1'b1;
        flag_wr_o.zero = 1'b1;
      end
      default: begin
        result_o = 8'h00; // No operation, nothing written
      end
    endcase
  end

  // Flag values; borrow bits are set when no borrow occurs
  always_comb begin
    flags_o.borrow = ~diff[8];
    flags_o.nibble_borrow_flag = ~ndiff[4];
    flags_o.zero = (result_o == 8'h00);
  end

endmodule

// >>> sxsalu_fregs.sv
`include "sxsalu_params.svh"

module sxsalu_fregs (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [6:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  input wire logic wr_en_i,
  input wire logic [6:0] wr_addr_i,
  input wire logic [7:0] wr_data_i
);
  import sxsalu_pkg::*;

  logic [7:0] mem_reg [`SXSALU_FILE_DEPTH]; // File register storage
  logic [7:0] mem_next [`SXSALU_FILE_DEPTH]; // Storage after write

  // Asynchronous read so an operand is ready in the same cycle
  assign rd_data_o = mem_reg[rd_addr_i];

  // One write port
  always_comb begin
    mem_next = mem_reg;
    if (wr_en_i) begin
      mem_next[wr_addr_i] = wr_data_i;
    end
  end

  // Storage registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < `SXSALU_FILE_DEPTH; i++) begin
        mem_reg[i] <= `SXSALU_RST_FILE;
      end
    end else begin
      mem_reg <= mem_next;
    end
  end

endmodule

// >>> sxsalu_params.svh
// Behaviour
// - Literal minus accumulator, result into accumulator
// - Literal subtract: borrow, nibble borrow and zero flags
// - File minus accumulator with both borrow flags
// - Seven-bit file address, destination bit selects target
// - Accumulator xor file, only zero flag
// - Nibble exchange of file, flags untouched
// - Accumulator xor literal into accumulator, zero only
`ifndef SXSALU_PARAMS_SVH
`define SXSALU_PARAMS_SVH

// Byte offsets of the register window on the bus
`define SXSALU_OFS_ACC 8'h00
`define SXSALU_OFS_STATUS 8'h04
`define SXSALU_OFS_CMD 8'h08
`define SXSALU_OFS_FADDR 8'h0C
`define SXSALU_OFS_FDATA 8'h10

// Status bit positions
`define SXSALU_ST_BORROW 0
`define SXSALU_ST_NIBBLE 1
`define SXSALU_ST_ZERO 2

// Reset values
`define SXSALU_RST_ACC 8'h00
`define SXSALU_RST_STATUS 3'h0
`define SXSALU_RST_FADDR 7'h00
`define SXSALU_RST_FILE 8'h00

// Size of the file register space
`define SXSALU_FILE_DEPTH 128

`endif

// >>> sxsalu_pkg.sv
package sxsalu_pkg;

  // Operation codes carried in the command word
  typedef enum logic [2:0] {
    SXSALU_OP_NONE,
    SXSALU_OP_LIT_MINUS_ACC,
    SXSALU_OP_FILE_MINUS_ACC,
    SXSALU_OP_ACC_XOR_FILE,
    SXSALU_OP_NIBBLE_EXCHANGE,
    SXSALU_OP_ACC_XOR_LITERAL
  } sxsalu_op_type;

  // Command word as written by software
  typedef struct packed {
    logic [12:0] unused;
    sxsalu_op_type op;
    logic dest;
    logic [6:0] faddr;
    logic [7:0] literal;
  } sxsalu_cmd_type;

  // Status flags, bit 2 downward
  typedef struct packed {
    logic zero;
    logic nibble_borrow_flag;
    logic borrow;
  } sxsalu_flags_type;

  // Bus slave phases
  typedef enum logic [1:0] {
    SXSALU_BUS_IDLE,
    SXSALU_BUS_WRITE,
    SXSALU_BUS_RDWAIT,
    SXSALU_BUS_RDDATA
  } sxsalu_bus_type;

endpackage

// >>> sxsalu_properties.sv
// Bus-side checker, sees only the top ports
module sxsalu_properties (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take; // Address phase accepted
  logic rd_reg; // Read data phase pending
  logic wr_reg; // Write data phase pending
  logic [31:0] a_reg; // Address of pending phase
  logic done; // Read data valid this cycle
  assign take = hsel_i & htrans_i[1] & hready_i;
  assign done = rd_reg & hreadyout_o;
  // Track the address phase into its data phase
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      a_reg <= 32'h0;
    end else if (hready_i) begin
      rd_reg <= take & ~hwrite_i;
      wr_reg <= take & hwrite_i;
      a_reg <= haddr_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  resp_okay_a: assert property (hresp_o == 1'b0)
    else $error("response not OKAY");
  rd_wait_a: assert property (take & ~hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  wr_nowait_a: assert property (take & hwrite_i |=> hreadyout_o)
    else $error("write stalled");
  unmapped_zero_a: assert property
    (done & (a_reg[31:8] != 24'h0 || a_reg[1:0] != 2'h0) |-> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  cmd_zero_a: assert property (done & a_reg == 32'h8 |-> hrdata_o == 32'h0)
    else $error("command read not zero");
  acc_width_a: assert property (done & a_reg == 32'h0 |-> hrdata_o[31:8] == 24'h0)
    else $error("accumulator wider than a byte");
  faddr_width_a: assert property (done & a_reg == 32'hC |-> hrdata_o[31:7] == 25'h0)
    else $error("file address wider than seven bits");
  status_width_a: assert property (done & a_reg == 32'h4 |-> hrdata_o[31:3] == 29'h0)
    else $error("status wider than three flags");
  rdata_hold_a: assert property (!(rd_reg & !hreadyout_o) |=> $stable(hrdata_o))
    else $error("read data changed without a read");
endmodule

bind sxsalu_top sxsalu_properties i_sxsalu_properties (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .hrdata_o(hrdata_o));

// >>> sxsalu_top.sv
`include "sxsalu_params.svh"

module sxsalu_top (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o
);
  import sxsalu_pkg::*;

  // Bus slave state
  sxsalu_bus_type bus_reg; // Current bus phase
  sxsalu_bus_type bus_next; // Next bus phase
  logic [7:0] idx_reg; // Captured byte offset
  logic [7:0] idx_next; // Next captured offset
  logic hit_reg; // Address is word aligned and inside window
  logic hit_next; // Next window hit
  logic [31:0] hrdata_reg; // Read data register
  logic [31:0] hrdata_next; // Next read data
  logic take; // Address phase accepted this edge

  // Datapath state
  logic [7:0] acc_reg; // Accumulator
  logic [7:0] acc_next; // Next accumulator
  sxsalu_flags_type status_reg; // Status flags
  sxsalu_flags_type status_next; // Next status flags
  logic [6:0] faddr_reg; // Pointer for direct file access
  logic [6:0] faddr_next; // Next pointer

  // Decoded write strobes in the data phase
  logic wr_phase; // Write data phase with a hit
  logic wr_acc; // Software writes accumulator
  logic wr_status; // Software writes status
  logic wr_cmd; // Software issues a command
  logic wr_faddr; // Software writes file pointer
  logic wr_fdata; // Software writes file data

  // Command decode and execution results
  sxsalu_cmd_type cmd; // Command word from write data
  sxsalu_op_type exec_op; // Operation presented to the ALU
  logic [7:0] exec_result; // ALU result
  sxsalu_flags_type exec_flags; // ALU flag values
  sxsalu_flags_type exec_flag_wr; // Flags the ALU updates
  logic exec_acc_wr; // ALU result goes to accumulator
  logic exec_file_wr; // ALU result goes to file register

  // File register port signals
  logic [6:0] file_rd_addr; // Read address
  logic [7:0] file_rd_data; // Read data
  logic file_wr_en; // Write enable
  logic [6:0] file_wr_addr; // Write address
  logic [7:0] file_wr_data; // Write data

  // Address phase accepted when selected, active and bus ready
  assign take = hsel_i & htrans_i[1] & hready_i;

  // Only reads insert a wait state; all answers are OKAY
  assign hreadyout_o = (bus_reg != SXSALU_BUS_RDWAIT);
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_reg;

  // Write strobes decoded from the captured address
  always_comb begin
    wr_phase = (bus_reg == SXSALU_BUS_WRITE) & hit_reg;
    wr_acc = wr_phase & (idx_reg == `SXSALU_OFS_ACC);
    wr_status = wr_phase & (idx_reg == `SXSALU_OFS_STATUS);
    wr_cmd = wr_phase & (idx_reg == `SXSALU_OFS_CMD);
    wr_faddr = wr_phase & (idx_reg == `SXSALU_OFS_FADDR);
    wr_fdata = wr_phase & (idx_reg == `SXSALU_OFS_FDATA);
  end

  // Command word fields; only a command write executes
  always_comb begin
    cmd = sxsalu_cmd_type'(hwdata_i);
    exec_op = wr_cmd ? cmd.op : SXSALU_OP_NONE;
  end

  // File read address: command operand, else the pointer
  always_comb begin
    if (wr_cmd) begin
      file_rd_addr = cmd.faddr;
    end else begin
      file_rd_addr = faddr_reg;
    end
  end

  // Arithmetic and logic unit
  sxsalu_exec u_exec (
    .op_i (exec_op),
    .dest_i (cmd.dest),
    .acc_i (acc_reg),
    .literal_i (cmd.literal),
    .file_i (file_rd_data),
    .result_o (exec_result),
    .flags_o (exec_flags),
    .flag_wr_o (exec_flag_wr),
    .acc_wr_o (exec_acc_wr),
    .file_wr_o (exec_file_wr)
  );

  // File write port: command result or direct data write
  always_comb begin
    file_wr_en = 1'b0;
    file_wr_addr = faddr_reg;
    file_wr_data = hwdata_i[7:0];
    if (exec_file_wr) begin
      file_wr_en = 1'b1;
      file_wr_addr = cmd.faddr;
      file_wr_data = exec_result;
    end else if (wr_fdata) begin
      file_wr_en = 1'b1;
    end
  end

  // File register space
  sxsalu_fregs u_fregs (
    .clk_i (clk_i),
    .arst_n_i (arst_n_i),
    .rd_addr_i (file_rd_addr),
    .rd_data_o (file_rd_data),
    .wr_en_i (file_wr_en),
    .wr_addr_i (file_wr_addr),
    .wr_data_i (file_wr_data)
  );

  // Datapath next state
  always_comb begin
    acc_next = acc_reg;
    status_next = status_reg;
    faddr_next = faddr_reg;
    // Direct software writes
    if (wr_acc) begin
      acc_next = hwdata_i[7:0];
    end
    if (wr_status) begin
      status_next = sxsalu_flags_type'(hwdata_i[2:0]);
    end
    if (wr_faddr) begin
      faddr_next = hwdata_i[6:0];
    end
    // Result into accumulator when selected
    if (exec_acc_wr) begin
      acc_next = exec_result;
    end
    // Per-flag update; untouched flags keep their value
    if (exec_flag_wr.borrow) begin
      status_next.borrow = exec_flags.borrow;
    end
    if (exec_flag_wr.nibble_borrow_flag) begin
      status_next.nibble_borrow_flag =
        exec_flags.nibble_borrow_flag;
    end
    if (exec_flag_wr.zero) begin
      status_next.zero = exec_flags.zero;
    end
  end

  // Datapath registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_reg <= `SXSALU_RST_ACC;
      status_reg <= `SXSALU_RST_STATUS;
      faddr_reg <= `SXSALU_RST_FADDR;
    end else begin
      acc_reg <= acc_next;
      status_reg <= status_next;
      faddr_reg <= faddr_next;
    end
  end

  // Bus phase sequencing and read data capture
  always_comb begin
    bus_next = SXSALU_BUS_IDLE;
    idx_next = idx_reg;
    hit_next = hit_reg;
    hrdata_next = hrdata_reg;
    case (bus_reg)
      SXSALU_BUS_RDWAIT: begin
        // Registers are settled now; sample the selected one
        bus_next = SXSALU_BUS_RDDATA;
        hrdata_next = 32'h0000_0000;
        if (hit_reg) begin
          case (idx_reg)
            `SXSALU_OFS_ACC: hrdata_next = {24'h00_0000, acc_reg};
            `SXSALU_OFS_STATUS: hrdata_next = {29'h0, status_reg};
            `SXSALU_OFS_FADDR: hrdata_next = {25'h0, faddr_reg};
            `SXSALU_OFS_FDATA: hrdata_next = {24'h00_0000, file_rd_data};
            default: hrdata_next = 32'h0000_0000;
          endcase
        end
      end
      default: begin
        // Idle, write data phase or read data phase
        bus_next = SXSALU_BUS_IDLE;
      end
    endcase
    // A new address phase may overlap the current data phase
    if (take) begin
      bus_next = hwrite_i ? SXSALU_BUS_WRITE : SXSALU_BUS_RDWAIT;
      idx_next = haddr_i[7:0];
      hit_next = (haddr_i[31:8] == 24'h00_0000) & (haddr_i[1:0] == 2'h0);
    end
  end

  // Bus slave registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_reg <= SXSALU_BUS_IDLE;
      idx_reg <= 8'h00;
      hit_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      bus_reg <= bus_next;
      idx_reg <= idx_next;
      hit_reg <= hit_next;
      hrdata_reg <= hrdata_next;
    end
  end

endmodule

// >>> tb_top.sv
// Register-level bench for the subtract, xor and swap datapath
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sxsalu_pkg::*;
  logic clk_i = 1'b0; // 200 MHz clock
  logic arst_n_i = 1'b0; // Held low at start
  logic [1:0] htrans = 2'h0; // Bus transfer type
  logic hwrite = 1'b0; // Bus direction
  logic [31:0] haddr = 32'h0; // Bus address
  logic [31:0] hwdata = 32'h0; // Bus write data
  logic [31:0] hrdata; // Bus read data
  logic [31:0] rdv; // Last read value
  logic hready; // Slave ready fed back
  logic hresp; // Slave response
  int n_errors = 0;
  int n_checks = 0;
  // Clock generator
  always #2.5 clk_i = ~clk_i;
  sxsalu_top i_sxsalu_top (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata));
  // Compare and count
  task check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task results;
    $display("Checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One single transfer: address phase, then data phase
  task bus(logic w, logic [31:0] a, logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rdv = hrdata;
  endtask
  task wr(logic [31:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(logic [31:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // Load operands, issue a command, compare acc, file and flags
  task run_op(logic [2:0] op, logic d, logic [6:0] fa, logic [7:0] lit,
              logic [7:0] a, logic [7:0] f, logic [2:0] st);
    logic [7:0] r;
    logic [7:0] o;
    logic [7:0] ea;
    logic [7:0] ef;
    logic [2:0] es;
    wr(32'hC, {25'h0, fa});
    wr(32'h10, {24'h0, f});
    wr(32'h0, {24'h0, a});
    wr(32'h4, {29'h0, st});
    wr(32'h8, {13'h0, op, d, fa, lit});
    ea = a;
    ef = f;
    es = st;
    o = (op == 3'h1) ? lit : f;
    case (op)
      3'h1, 3'h2: r = o - a;
      3'h3: r = a ^ f;
      3'h4: r = {f[3:0], f[7:4]};
      3'h5: r = a ^ lit;
      default: r = 8'h00;
    endcase
    // Borrow flags only for the two subtracts
    if (op == 3'h1 || op == 3'h2) es[1:0] = {o[3:0] >= a[3:0], o >= a};
    // Zero flag for both subtracts and both xors, not the swap
    if (op inside {3'h1, 3'h2, 3'h3, 3'h5}) es[2] = (r == 8'h00);
    // Destination: literal ops always to the accumulator
    if (op inside {3'h2, 3'h3, 3'h4} && d) ef = r;
    else if (op inside {[3'h1:3'h5]}) ea = r;
    rd(32'h0);
    check("acc", rdv, {24'h0, ea});
    rd(32'h10);
    check("file", rdv, {24'h0, ef});
    rd(32'h4);
    check("status", rdv, {29'h0, es});
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    // Reset values of the whole window
    for (int i = 0; i < 5; i++) begin
      rd(32'(i * 4));
      check("reset", rdv, 32'h0);
    end
    run_op(SXSALU_OP_LIT_MINUS_ACC, 1'b0, 7'h00, 8'h05, 8'h05, 8'h00, 3'h0);
    run_op(SXSALU_OP_LIT_MINUS_ACC, 1'b1, 7'h00, 8'h05, 8'h06, 8'h00, 3'h7);
    run_op(SXSALU_OP_LIT_MINUS_ACC, 1'b0, 7'h00, 8'h20, 8'h1F, 8'h00, 3'h0);
    run_op(SXSALU_OP_LIT_MINUS_ACC, 1'b0, 7'h00, 8'hFF, 8'h00, 8'h00, 3'h0);
    run_op(SXSALU_OP_FILE_MINUS_ACC, 1'b0, 7'h7F, 8'h00, 8'h01, 8'h80, 3'h0);
    run_op(SXSALU_OP_FILE_MINUS_ACC, 1'b1, 7'h7F, 8'h00, 8'h80, 8'h80, 3'h0);
    run_op(SXSALU_OP_FILE_MINUS_ACC, 1'b1, 7'h01, 8'h00, 8'h81, 8'h80, 3'h7);
    run_op(SXSALU_OP_ACC_XOR_FILE, 1'b0, 7'h05, 8'h00, 8'hA5, 8'hA5, 3'h3);
    run_op(SXSALU_OP_ACC_XOR_FILE, 1'b1, 7'h06, 8'h00, 8'h0F, 8'hF0, 3'h4);
    run_op(SXSALU_OP_NIBBLE_EXCHANGE, 1'b0, 7'h07, 8'h00, 8'h33, 8'hA5, 3'h7);
    run_op(SXSALU_OP_NIBBLE_EXCHANGE, 1'b1, 7'h7F, 8'h00, 8'h33, 8'hC3, 3'h0);
    run_op(SXSALU_OP_ACC_XOR_LITERAL, 1'b1, 7'h00, 8'hFF, 8'hFF, 8'h12, 3'h3);
    run_op(SXSALU_OP_ACC_XOR_LITERAL, 1'b0, 7'h00, 8'h0F, 8'hF0, 8'h00, 3'h4);
    // Unused command codes leave everything alone
    run_op(3'h0, 1'b1, 7'h08, 8'hAA, 8'h11, 8'h22, 3'h5);
    run_op(3'h6, 1'b1, 7'h08, 8'hAA, 8'h11, 8'h22, 3'h5);
    run_op(3'h7, 1'b0, 7'h08, 8'hAA, 8'h11, 8'h22, 3'h2);
    // Unmapped and misaligned places and the command register read zero
    wr(32'h102, 32'hFF);
    rd(32'h102);
    check("unmapped", rdv, 32'h0);
    rd(32'h8);
    check("command", rdv, 32'h0);
    results();
  end
  // Watchdog against a hung handshake
  initial begin
    #100000;
    n_errors++;
    results();
  end
endmodule
